// ---- bench/tcc_pin_src.sv ----
// pulse sources standing in for the external capture pins
`timescale 1ns/1ps
module tcc_pin_src (
    input wire aclk,
    output logic [4:0] pins
);
initial pins = 5'h00;
// levels held whole cycles so a one-flop edge detector sees each one
task automatic pulse(input int i, input int hi, input int lo);
    pins[i] <= 1'b1;
    repeat (hi) @(posedge aclk);
    pins[i] <= 1'b0;
    repeat (lo) @(posedge aclk);
endtask
task automatic level(input int i, input logic v);
    pins[i] <= v;
    repeat (4) @(posedge aclk);
endtask
endmodule // tcc_pin_src

// ---- bench/tcc_top_asserts.sv ----
// concurrent checks on the dual timer top, bound to its ports
`timescale 1ns/1ps
module tcc_top_asserts (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire capture_pin_first_a,
    input wire timer_out_a,
    input wire timer_out_extra_a,
    input wire ext_irq_a,
    input wire match_irq_first_a,
    input wire match_irq_second_a
);
default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);
a_reset_quiet: assert property ($rose(aresetn) |->
    !timer_out_a && !timer_out_extra_a && !ext_irq_a)
    else $error("outputs not cleared by reset");
// capture_pin_first_a is held at least four cycles, so a real edge spans this window
a_ext_cause: assert property (ext_irq_a |->
    $past(capture_pin_first_a, 1) != $past(capture_pin_first_a, 4))
    else $error("ext irq without a pin edge");
a_ext_single: assert property (ext_irq_a |=> !ext_irq_a)
    else $error("ext irq longer than one cycle");
a_match_single: assert property (match_irq_first_a |=>
    !match_irq_first_a)
    else $error("first match irq not a pulse");
a_clear_single: assert property (match_irq_second_a |=>
    !match_irq_second_a)
    else $error("second match irq not a pulse");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
a_busy_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule // tcc_top_asserts
bind tcc_top tcc_top_asserts u_tcc_top_asserts (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .capture_pin_first_a(capture_pin_first_a),
    .timer_out_a(timer_out_a), .timer_out_extra_a(timer_out_extra_a),
    .ext_irq_a(ext_irq_a), .match_irq_first_a(match_irq_first_a),
    .match_irq_second_a(match_irq_second_a));

// ---- bench/test_timer16_capture_compare.sv ----
// self-checking bench for the dual capture/compare timer
`timescale 1ns/1ps
`include "tcc_defines.vh"
module test_timer16_capture_compare;
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic [7:0] awaddr = 8'h00, araddr = 8'h00;
logic [31:0] wdata = 32'h0, rdata, got;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic awready, wready, bvalid, arready, rvalid;
logic [1:0] bresp, rresp, rsp;
logic [4:0] pins;
logic out_a, out_x, out_b, eirq_a, m1a, m2a, eirq_b, m1b, m2b;
int errors = 0, compares = 0, n_ext = 0, n_m1 = 0, n_m2 = 0, e;
int n_eb = 0, n_m1b = 0, n_m2b = 0;
always #20 aclk = ~aclk;
tcc_pin_src u_tcc_pin_src (.aclk(aclk), .pins(pins));
tcc_top u_tcc_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_pin_first_a(pins[0]),
    .capture_pin_second_a(pins[1]), .capture_pin_first_b(pins[2]),
    .capture_pin_second_b(pins[3]), .eight_bit_timer_flop(pins[4]),
    .timer_out_a(out_a), .timer_out_extra_a(out_x), .timer_out_b(out_b),
    .ext_irq_a(eirq_a), .ext_irq_b(eirq_b), .match_irq_first_a(m1a),
    .match_irq_second_a(m2a), .match_irq_first_b(m1b),
    .match_irq_second_b(m2b));
always @(posedge aclk) begin
    if (eirq_a === 1'b1) n_ext <= n_ext + 1;
    if (m1a === 1'b1) n_m1 <= n_m1 + 1;
    if (m2a === 1'b1) n_m2 <= n_m2 + 1;
    if (eirq_b === 1'b1) n_eb <= n_eb + 1;
    if (m1b === 1'b1) n_m1b <= n_m1b + 1;
    if (m2b === 1'b1) n_m2b <= n_m2b + 1;
end
task automatic summarize;
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
        errors++;
        $display("wrong value %s expected %h seen %h", n, x, s);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
        @(negedge aclk);
        ah = awvalid && awready;
        wh = wvalid && wready;
        bh = bvalid && bready;
        if (bh) rsp = bresp;
        @(posedge aclk);
        if (ah) awvalid <= 1'b0;
        if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
    @(posedge aclk);
endtask
task automatic rd(input logic [7:0] a);
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
        @(negedge aclk);
        ah = arvalid && arready;
        rh = rvalid && rready;
        if (rh) got = rdata;
        if (rh) rsp = rresp;
        @(posedge aclk);
        if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
    @(posedge aclk);
endtask
task automatic rc(input logic [7:0] a, input logic [31:0] x, input string n);
    rd(a);
    chk(n, got, x);
endtask
task automatic ticks(input int n);
    repeat (n) u_tcc_pin_src.pulse(0, 4, 4);
endtask
task automatic t_reset;
    rc(`TCC_OFF_MODE, 32'h20, "mode_a");
    rc(`TCC_OFF_FLOP, 32'hC3, "flop_a");
    rc(`TCC_CH_STRIDE + `TCC_OFF_MODE, 32'h20, "mode_b");
    rc(8'h3C, 32'h0, "unmapped_data");
    chk("unmapped_rresp", {30'h0, rsp}, 32'h2);
    wr(8'h3C, 32'h1);
    chk("unmapped_bresp", {30'h0, rsp}, 32'h2);
endtask
task automatic t_event;
    e = n_ext;
    wr(`TCC_OFF_RUN, 32'h81);
    ticks(5);
    rc(`TCC_OFF_CNT, 32'h5, "count_a");
    chk("rise_irqs", n_ext, e + 5);
    rc(`TCC_CH_STRIDE + `TCC_OFF_CNT, 32'h0, "count_b");
    wr(`TCC_OFF_FLOP, 32'hD3);
    // bit 5 low is the software capture request
    wr(`TCC_OFF_MODE, 32'h00);
    rc(`TCC_OFF_CAPF, 32'h5, "soft_cap");
    chk("soft_cap_flop", out_a, 1);
    wr(`TCC_OFF_RUN, 32'h80);
    rc(`TCC_OFF_CNT, 32'h0, "stopped");
    chk("out_b", out_b, 0);
endtask
task automatic t_capture;
    wr(`TCC_OFF_RUN, 32'h81);
    ticks(3);
    wr(`TCC_OFF_MODE, 32'h20);
    u_tcc_pin_src.pulse(1, 4, 4);
    rc(`TCC_OFF_CAPS, 32'h0, "cap_off");
    wr(`TCC_OFF_MODE, 32'h28);
    u_tcc_pin_src.pulse(1, 2, 6);
    rc(`TCC_OFF_CAPS, 32'h3, "cap_two_pin");
    wr(`TCC_OFF_MODE, 32'h30);
    e = n_ext;
    u_tcc_pin_src.level(0, 1'b1);
    chk("irq_on_rise", n_ext, e);
    u_tcc_pin_src.level(0, 1'b0);
    chk("irq_on_fall", n_ext, e + 1);
    rc(`TCC_OFF_CAPS, 32'h4, "cap_width");
    wr(`TCC_OFF_MODE, 32'h38);
    u_tcc_pin_src.level(4, 1'b1);
    rc(`TCC_OFF_CAPF, 32'h4, "cap_flop_rise");
    ticks(1);
    u_tcc_pin_src.level(4, 1'b0);
    rc(`TCC_OFF_CAPS, 32'h5, "cap_flop_fall");
    wr(`TCC_OFF_RUN, 32'h80);
endtask
task automatic t_compare;
    logic [1:0] cmd [3] = '{2'b01, 2'b10, 2'b00};
    logic [31:0] want [3] = '{32'h1, 32'h0, 32'h1};
    wr(`TCC_OFF_CMP1, 32'h2);
    wr(`TCC_OFF_CMP2, 32'h4);
    wr(`TCC_OFF_MODE, 32'h24);
    wr(`TCC_OFF_FLOP, 32'hCE);
    e = n_m1;
    wr(`TCC_OFF_RUN, 32'h81);
    ticks(3);
    chk("pulse_first", out_a, 1);
    chk("irq_first", n_m1, e + 1);
    e = n_m2;
    ticks(2);
    chk("pulse_second", out_a, 0);
    chk("irq_second", n_m2, e + 1);
    rc(`TCC_OFF_CNT, 32'h0, "cleared");
    wr(`TCC_OFF_MODE, 32'h20);
    ticks(5);
    rc(`TCC_OFF_CNT, 32'h5, "free_run");
    for (int i = 0; i < 3; i++) begin
        wr(`TCC_OFF_FLOP, {24'h0, 6'h30, cmd[i]});
        chk("soft_flop", out_a, want[i]);
        rc(`TCC_OFF_STAT, want[i], "status");
    end
    wr(`TCC_OFF_RUN, 32'h80);
endtask
task automatic t_dbuf;
    wr(`TCC_OFF_FLOP, 32'h8E);
    wr(`TCC_OFF_MODE, 32'h164);
    wr(`TCC_OFF_CMP1, 32'h3);
    wr(`TCC_OFF_RUN, 32'h81);
    ticks(3);
    chk("old_cmp_live", out_a, 1);
    ticks(2);
    chk("extra_flop", out_x, 1);
    ticks(3);
    chk("moved_cmp", out_a, 0);
    ticks(1);
    chk("new_cmp_hit", out_a, 1);
    wr(`TCC_OFF_RUN, 32'h80);
endtask
task automatic t_chan_b;
    e = n_eb;
    wr(`TCC_CH_STRIDE + `TCC_OFF_CMP1, 32'h1);
    wr(`TCC_CH_STRIDE + `TCC_OFF_CMP2, 32'h2);
    wr(`TCC_CH_STRIDE + `TCC_OFF_FLOP, 32'hC7);
    wr(`TCC_OFF_RUN, 32'h82);
    repeat (3) u_tcc_pin_src.pulse(2, 4, 4);
    rc(`TCC_CH_STRIDE + `TCC_OFF_CNT, 32'h3, "count_b_pin");
    chk("rise_irqs_b", n_eb, e + 3);
    chk("match_first_b", n_m1b, 1);
    chk("match_second_b", n_m2b, 1);
    chk("out_b_toggled", out_b, 1);
    rc(`TCC_OFF_CNT, 32'h0, "count_a_idle");
    wr(`TCC_CH_STRIDE + `TCC_OFF_MODE, 32'h29);
    // 64 cycles between the two rises hold exactly eight divide-by-8 ticks
    u_tcc_pin_src.level(2, 1'b1);
    repeat (60) @(posedge aclk);
    u_tcc_pin_src.level(3, 1'b1);
    rd(`TCC_CH_STRIDE + `TCC_OFF_CAPF);
    e = got + 64 / `TCC_DIV_T1;
    rc(`TCC_CH_STRIDE + `TCC_OFF_CAPS, e, "div8_gap");
    u_tcc_pin_src.level(2, 1'b0);
    u_tcc_pin_src.level(3, 1'b0);
    wr(`TCC_OFF_RUN, 32'h80);
endtask
// about 550 cycles of traffic; the margin covers a stuck handshake
initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    summarize;
end
initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_event;
    t_capture;
    t_compare;
    t_dbuf;
    t_chan_b;
    summarize;
end
endmodule // test_timer16_capture_compare

// ---- rtl/tcc_channel.v ----
// one 16-bit counter channel: clock select, capture, compare, flip-flops
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_channel #(
    parameter HAS_EXTRA = 1,
    parameter WIDTH = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire pre_run,
    input wire tick1,
    input wire tick4,
    input wire tick16,
    input wire [1:0] clk_sel,
    input wire clear_en,
    input wire [1:0] cap_mode,
    input wire [3:0] trig_en,
    input wire [1:0] xtrg_en,
    input wire dbuf_en,
    input wire pin_first,
    input wire pin_second,
    input wire eight_bit_timer_flop,
    input wire soft_capture,
    input wire [1:0] flop_cmd,
    input wire flop_cmd_we,
    input wire [1:0] xflop_cmd,
    input wire xflop_cmd_we,
    input wire cmp1_we,
    input wire cmp2_we,
    input wire [WIDTH-1:0] wdata,
    output reg [WIDTH-1:0] counter_reg,
    output reg [WIDTH-1:0] capture_first_reg,
    output reg [WIDTH-1:0] capture_second_reg,
    output reg [WIDTH-1:0] compare_first_reg,
    output reg [WIDTH-1:0] compare_buf_reg,
    output reg [WIDTH-1:0] compare_second_reg,
    output reg main_flop_reg,
    output reg extra_flop_reg,
    output reg match_irq_first,
    output reg match_irq_second,
    output reg ext_irq
);
    reg p1_reg;
    reg p2_reg;
    reg f_reg;
    wire p1_rise = pin_first & ~p1_reg;
    wire p1_fall = ~pin_first & p1_reg;
    wire p2_rise = pin_second & ~p2_reg;
    wire f_rise = eight_bit_timer_flop & ~f_reg;
    wire f_fall = ~eight_bit_timer_flop & f_reg;
    reg capf_ev;
    reg caps_ev;
    reg tick;
    // hardware capture event selection
    always @* begin
        capf_ev = 1'b0;
        caps_ev = 1'b0;
        case (cap_mode)
            `TCC_CAP_OFF: begin
                capf_ev = 1'b0;
            end
            `TCC_CAP_TWO: begin
                capf_ev = p1_rise;
                caps_ev = p2_rise;
            end
            `TCC_CAP_WIDTH: begin
                capf_ev = p1_rise;
                caps_ev = p1_fall;
            end
            default: begin
                capf_ev = f_rise;
                caps_ev = f_fall;
            end
        endcase
    end
    always @* begin
        case (clk_sel)
            `TCC_CLK_PIN: tick = p1_rise;
            2'b01: tick = tick1;
            2'b10: tick = tick4;
            default: tick = tick16;
        endcase
    end
    wire match1 = counter_reg == compare_first_reg;
    wire match2 = counter_reg == compare_second_reg;
    // matches only count once per count value, on the tick that leaves it
    wire hit1 = run & tick & match1;
    wire hit2 = run & tick & match2;
    wire soft_ev = soft_capture & pre_run;
    wire c1_any = capf_ev | soft_ev;
    wire tog = (trig_en[0] & hit1) | (trig_en[1] & hit2) |
               (trig_en[2] & c1_any) | (trig_en[3] & caps_ev);
    wire xtog = (xtrg_en[0] & hit2) | (xtrg_en[1] & caps_ev);
    always @(posedge aclk) begin
        if (!aresetn) begin
            p1_reg <= 1'b0;
            p2_reg <= 1'b0;
            f_reg <= 1'b0;
            counter_reg <= {WIDTH{1'b0}};
            capture_first_reg <= {WIDTH{1'b0}};
            capture_second_reg <= {WIDTH{1'b0}};
            compare_first_reg <= {WIDTH{1'b0}};
            compare_buf_reg <= {WIDTH{1'b0}};
            compare_second_reg <= {WIDTH{1'b0}};
            main_flop_reg <= 1'b0;
            extra_flop_reg <= 1'b0;
            match_irq_first <= 1'b0;
            match_irq_second <= 1'b0;
            ext_irq <= 1'b0;
        end else begin
            p1_reg <= pin_first;
            p2_reg <= pin_second;
            f_reg <= eight_bit_timer_flop;
            if (!run)
                counter_reg <= {WIDTH{1'b0}};
            else if (tick) begin
                if (match2 & clear_en)
                    counter_reg <= {WIDTH{1'b0}};
                else
                    counter_reg <= counter_reg + 1'b1;
            end
            if (c1_any)
                capture_first_reg <= counter_reg;
            if (caps_ev)
                capture_second_reg <= counter_reg;
            if (cmp1_we) begin
                compare_buf_reg <= wdata;
                if (!dbuf_en)
                    compare_first_reg <= wdata;
            end else if (dbuf_en & hit2)
                compare_first_reg <= compare_buf_reg;
            if (cmp2_we)
                compare_second_reg <= wdata;
            // software command wins over a hardware toggle in that cycle
            if (flop_cmd_we & flop_cmd == `TCC_FF_TOGGLE)
                main_flop_reg <= ~main_flop_reg;
            else if (flop_cmd_we & flop_cmd == `TCC_FF_SET)
                main_flop_reg <= 1'b1;
            else if (flop_cmd_we & flop_cmd == `TCC_FF_CLEAR)
                main_flop_reg <= 1'b0;
            else if (tog)
                main_flop_reg <= ~main_flop_reg;
            if (HAS_EXTRA == 0)
                extra_flop_reg <= 1'b0;
            else if (xflop_cmd_we & xflop_cmd == `TCC_FF_TOGGLE)
                extra_flop_reg <= ~extra_flop_reg;
            else if (xflop_cmd_we & xflop_cmd == `TCC_FF_SET)
                extra_flop_reg <= 1'b1;
            else if (xflop_cmd_we & xflop_cmd == `TCC_FF_CLEAR)
                extra_flop_reg <= 1'b0;
            else if (xtog)
                extra_flop_reg <= ~extra_flop_reg;
            match_irq_first <= hit1;
            match_irq_second <= hit2;
            ext_irq <= (cap_mode == `TCC_CAP_WIDTH) ? p1_fall : p1_rise;
        end
    end
endmodule // tcc_channel

// ---- rtl/tcc_top.v ----
// dual 16-bit capture/compare timer with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_top (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire capture_pin_first_a,
    input wire capture_pin_second_a,
    input wire capture_pin_first_b,
    input wire capture_pin_second_b,
    input wire eight_bit_timer_flop,
    output wire timer_out_a,
    output wire timer_out_extra_a,
    output wire timer_out_b,
    output wire ext_irq_a,
    output wire ext_irq_b,
    output wire match_irq_first_a,
    output wire match_irq_second_a,
    output wire match_irq_first_b,
    output wire match_irq_second_b
);
    localparam W = 16;
    reg [7:0] run_reg;
    reg [8:0] mode_a_reg;
    reg [8:0] mode_b_reg;
    reg [5:0] flop_en_a_reg;
    reg [5:0] flop_en_b_reg;
    reg [`TCC_PRE_W-1:0] pre_reg;
    reg [7:0] aw_reg;
    reg aw_full_reg;
    reg [31:0] w_reg;
    reg [3:0] ws_reg;
    reg w_full_reg;

    // prescaler shared by both channels, stopped when its run bit is low
    wire pre_run = run_reg[`TCC_RUN_PRE];
    wire [`TCC_PRE_W-1:0] pre_next = pre_reg + 1'b1;
    wire tick1 = pre_run & (pre_next[2:0] == 3'h0);
    wire tick4 = pre_run & (pre_next[4:0] == 5'h00);
    wire tick16 = pre_run & (pre_next == 7'h00);
    always @(posedge aclk) begin
        if (!aresetn || !pre_run)
            pre_reg <= {`TCC_PRE_W{1'b0}};
        else
            pre_reg <= pre_next;
    end

    // write channel: address and data latched in either order
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    wire do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire [7:0] wa = aw_reg;
    wire [31:0] wd = w_reg;
    wire wl0 = ws_reg[0];
    wire wl1 = ws_reg[1];
    wire in_a = wa < `TCC_CH_STRIDE;
    wire [7:0] wo = in_a ? wa : wa - `TCC_CH_STRIDE;
    wire ch_hit = wa < (`TCC_CH_STRIDE + `TCC_CH_STRIDE);
    wire we_mode = do_wr & ch_hit & (wo == `TCC_OFF_MODE);
    wire we_flop = do_wr & ch_hit & (wo == `TCC_OFF_FLOP) & wl0;
    wire we_c1 = do_wr & ch_hit & (wo == `TCC_OFF_CMP1) & wl0 & wl1;
    wire we_c2 = do_wr & ch_hit & (wo == `TCC_OFF_CMP2) & wl0 & wl1;
    wire we_run = do_wr & (wa == `TCC_OFF_RUN) & wl0;
    wire wr_known = ch_hit ? (wo <= `TCC_OFF_CNT) :
                    (wa == `TCC_OFF_RUN || wa == `TCC_OFF_STAT);
    // soft capture: writing 0 to its bit in a mode write
    wire sc_a = we_mode & in_a & wl0 & ~wd[`TCC_MODE_SOFTCAP];
    wire sc_b = we_mode & ~in_a & wl0 & ~wd[`TCC_MODE_SOFTCAP];
    wire [1:0] fcmd = wd[`TCC_FLOP_CTL_LO +: 2];
    wire [1:0] xcmd = wd[`TCC_FLOP_XCTL_LO +: 2];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg <= 8'h00;
            aw_full_reg <= 1'b0;
            w_reg <= 32'h00000000;
            ws_reg <= 4'h0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            run_reg <= 8'h00;
            mode_a_reg <= 9'h000;
            mode_b_reg <= 9'h000;
            flop_en_a_reg <= 6'h00;
            flop_en_b_reg <= 6'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_reg <= {s_axi_awaddr[7:2], 2'b00};
                aw_full_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end
            if (do_wr) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (we_run)
                run_reg <= wd[7:0] & 8'h83;
            if (we_mode && in_a) begin
                if (wl0)
                    mode_a_reg[7:0] <= wd[7:0];
                if (wl1)
                    mode_a_reg[8] <= wd[`TCC_MODE_DBEN];
            end
            if (we_mode && !in_a) begin
                if (wl0)
                    mode_b_reg[7:0] <= wd[7:0] & 8'h3F;
                if (wl1)
                    mode_b_reg[8] <= wd[`TCC_MODE_DBEN];
            end
            if (we_flop && in_a)
                flop_en_a_reg <= wd[5:0];
            if (we_flop && !in_a)
                flop_en_b_reg <= wd[5:0];
        end
    end

    wire [W-1:0] cnt [0:1];
    wire [W-1:0] cap_fst [0:1];
    wire [W-1:0] cap_snd [0:1];
    wire [W-1:0] cmp1 [0:1];
    wire [W-1:0] cmpb [0:1];
    wire [W-1:0] cmp2 [0:1];
    wire [1:0] mflop;
    wire [1:0] xflop;
    wire [1:0] mi1;
    wire [1:0] mi2;
    wire [1:0] eirq;

    // independent channels; only channel a has the extra flop
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            wire [8:0] md = (g == 0) ? mode_a_reg : mode_b_reg;
            wire [5:0] fe = (g == 0) ? flop_en_a_reg : flop_en_b_reg;
            wire sel = (g == 0) ? in_a : ~in_a;
            tcc_channel #(
                .HAS_EXTRA(g == 0 ? 1 : 0),
                .WIDTH(W)
            ) u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .run(run_reg[g]),
                .pre_run(pre_run),
                .tick1(tick1),
                .tick4(tick4),
                .tick16(tick16),
                .clk_sel(md[`TCC_MODE_CLK_LO +: 2]),
                .clear_en(md[`TCC_MODE_CLE]),
                .cap_mode(md[`TCC_MODE_CAP_LO +: 2]),
                .trig_en(fe[`TCC_FLOP_EN_LO +: 4]),
                .xtrg_en(md[`TCC_MODE_XTRG_CMP +: 2]),
                .dbuf_en(md[`TCC_MODE_DBEN]),
                .pin_first(g == 0 ? capture_pin_first_a :
                           capture_pin_first_b),
                .pin_second(g == 0 ? capture_pin_second_a :
                            capture_pin_second_b),
                .eight_bit_timer_flop(eight_bit_timer_flop),
                .soft_capture(g == 0 ? sc_a : sc_b),
                .flop_cmd(fcmd),
                .flop_cmd_we(we_flop & sel),
                .xflop_cmd(xcmd),
                .xflop_cmd_we(we_flop & sel),
                .cmp1_we(we_c1 & sel),
                .cmp2_we(we_c2 & sel),
                .wdata(wd[W-1:0]),
                .counter_reg(cnt[g]),
                .capture_first_reg(cap_fst[g]),
                .capture_second_reg(cap_snd[g]),
                .compare_first_reg(cmp1[g]),
                .compare_buf_reg(cmpb[g]),
                .compare_second_reg(cmp2[g]),
                .main_flop_reg(mflop[g]),
                .extra_flop_reg(xflop[g]),
                .match_irq_first(mi1[g]),
                .match_irq_second(mi2[g]),
                .ext_irq(eirq[g])
            );
        end
    endgenerate

    assign timer_out_a = mflop[0];
    assign timer_out_b = mflop[1];
    assign timer_out_extra_a = xflop[0];
    assign ext_irq_a = eirq[0];
    assign ext_irq_b = eirq[1];
    assign match_irq_first_a = mi1[0];
    assign match_irq_second_a = mi2[0];
    assign match_irq_first_b = mi1[1];
    assign match_irq_second_b = mi2[1];

    // read channel: one read at a time, answered the cycle after arvalid
    assign s_axi_arready = !s_axi_rvalid;
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire r_a = ra < `TCC_CH_STRIDE;
    wire r_hit = ra < (`TCC_CH_STRIDE + `TCC_CH_STRIDE);
    wire [7:0] ro = r_a ? ra : ra - `TCC_CH_STRIDE;
    wire ri = r_a ? 1'b0 : 1'b1;
    reg [31:0] rd;
    reg rd_ok;
    always @* begin
        rd = 32'h00000000;
        rd_ok = 1'b1;
        if (r_hit) begin
            case (ro)
                `TCC_OFF_MODE: rd = {23'h000000,
                    (ri ? mode_b_reg[8] : mode_a_reg[8]), 2'b00, 1'b1,
                    (ri ? mode_b_reg[4:0] : mode_a_reg[4:0])} |
                    (ri ? 32'h0 : {24'h000000, mode_a_reg[7:6], 6'h00});
                // control fields always read as 11
                `TCC_OFF_FLOP: rd = {24'h000000, 2'b11,
                    (ri ? flop_en_b_reg[5:2] : flop_en_a_reg[5:2]), 2'b11};
                `TCC_OFF_CMP1: rd = {16'h0000, cmpb[ri]};
                `TCC_OFF_CMP2: rd = {16'h0000, cmp2[ri]};
                `TCC_OFF_CAPF: rd = {16'h0000, cap_fst[ri]};
                `TCC_OFF_CAPS: rd = {16'h0000, cap_snd[ri]};
                `TCC_OFF_CNT: rd = {16'h0000, cnt[ri]};
                default: rd_ok = 1'b0;
            endcase
        end else if (ra == `TCC_OFF_RUN)
            rd = {24'h000000, run_reg};
        else if (ra == `TCC_OFF_STAT)
            rd = {29'h00000000, xflop[0], mflop[1], mflop[0]};
        else
            rd_ok = 1'b0;
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // tcc_top

// ---- shared/tcc_defines.vh ----
// register map, field positions and encodings of the dual timer block
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH
`define TCC_ADDR_W 8
// per-channel register window: channel b sits at this stride
`define TCC_CH_STRIDE 8'h20
`define TCC_OFF_MODE 8'h00
`define TCC_OFF_FLOP 8'h04
`define TCC_OFF_CMP1 8'h08
`define TCC_OFF_CMP2 8'h0C
`define TCC_OFF_CAPF 8'h10
`define TCC_OFF_CAPS 8'h14
`define TCC_OFF_CNT 8'h18
`define TCC_OFF_RUN 8'h40
`define TCC_OFF_STAT 8'h44
// mode register fields
`define TCC_MODE_CLK_LO 0
`define TCC_MODE_CLE 2
`define TCC_MODE_CAP_LO 3
`define TCC_MODE_SOFTCAP 5
`define TCC_MODE_XTRG_CMP 6
`define TCC_MODE_XTRG_CAP 7
`define TCC_MODE_DBEN 8
// flop register fields
`define TCC_FLOP_CTL_LO 0
`define TCC_FLOP_EN_LO 2
`define TCC_FLOP_XCTL_LO 6
// run register fields
`define TCC_RUN_A 0
`define TCC_RUN_B 1
`define TCC_RUN_PRE 7
// encodings
`define TCC_CAP_OFF 2'b00
`define TCC_CAP_TWO 2'b01
`define TCC_CAP_WIDTH 2'b10
`define TCC_CAP_FLOP 2'b11
`define TCC_FF_TOGGLE 2'b00
`define TCC_FF_SET 2'b01
`define TCC_FF_CLEAR 2'b10
`define TCC_FF_IDLE 2'b11
`define TCC_CLK_PIN 2'b00
// prescaler tick periods in system clocks
`define TCC_DIV_T1 8
`define TCC_DIV_T4 32
`define TCC_DIV_T16 128
`define TCC_PRE_W 7
`endif
